// ==== src/fes_host.sv ====
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module fes_host #(
  parameter int unsigned GAP_CYCLES = fes_pkg::GAP_CYC
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [7:0]       haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  output fes_pkg::fes_pins_t    flash,
  input  wire logic [7:0]       dq_in
);
  fes_pkg::fes_state_t st_q;
  fes_pkg::fes_cmd_t   cmd_q;
  fes_pkg::fes_pins_t  pins_q;
  logic [2:0]  step_q;
  logic [7:0]  tmr_q;
  logic [16:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rd_q;
  logic [7:0]  prev_rd_q;
  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;
  logic [7:0]  sync3_q;
  logic [15:0] gap_q;
  logic        win_q;
  logic        late_q;
  logic        susp_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;

  // Bus decode
  wire addr_ph   = hsel & hready & htrans[1];
  wire wr_ctrl   = wr_pend_q & (wr_addr_q == fes_pkg::OFS_CTRL);
  wire wr_addr   = wr_pend_q & (wr_addr_q == fes_pkg::OFS_ADDR);
  wire wr_wdata  = wr_pend_q & (wr_addr_q == fes_pkg::OFS_WDATA);
  wire busy      = (st_q != fes_pkg::FES_ST_IDLE);
  wire [3:0] req = hwdata[3:0];
  // Late extra sectors would be dropped by the device, so they are refused here
  wire late_add  = (req == fes_pkg::FES_CMD_SEC_ADD) & ~win_q;
  wire bad_res   = (req == fes_pkg::FES_CMD_RESUME) & ~susp_q;
  wire go        = wr_ctrl & hwdata[31] & ~busy & ~late_add & ~bad_res;
  wire [31:0] status = {16'h0000, rd_q, 1'b0, rd_q[2] ^ prev_rd_q[2], rd_q[6] ^ prev_rd_q[6],
                        rd_q[7], rd_q[3], late_q, win_q, busy};
  wire [31:0] rmux = (haddr == fes_pkg::OFS_CTRL)   ? {28'h0000000, cmd_q} :
                     (haddr == fes_pkg::OFS_ADDR)   ? {15'h0000, addr_q} :
                     (haddr == fes_pkg::OFS_WDATA)  ? {24'h000000, wdata_q} :
                     (haddr == fes_pkg::OFS_STATUS) ? {susp_q, status[30:0]} : 32'h00000000;

  // Cycle table
  wire erase   = (cmd_q == fes_pkg::FES_CMD_CHIP) | (cmd_q == fes_pkg::FES_CMD_SECTOR);
  wire prog    = (cmd_q == fes_pkg::FES_CMD_PROGRAM);
  wire asel    = (cmd_q == fes_pkg::FES_CMD_AUTOSEL);
  wire single  = ~erase & ~prog & ~asel & (cmd_q != fes_pkg::FES_CMD_READ);
  wire [2:0] nwr = erase ? 3'd6 : prog ? 3'd4 : asel ? 3'd3 : single ? 3'd1 : 3'd0;
  wire last_wr = (step_q == nwr - 3'd1);
  wire unl_a   = ~single & ((step_q == 3'd0) | (erase & step_q == 3'd3));
  wire unl_b   = ~single & ((step_q == 3'd1) | (erase & step_q == 3'd4));
  wire [7:0] set_d = erase ? fes_pkg::D_ERASE_SET :
                     prog ? fes_pkg::D_PROG_SET : fes_pkg::D_AUTOSEL;
  wire [7:0] one_d = (cmd_q == fes_pkg::FES_CMD_RESET)   ? fes_pkg::D_RESET :
                     (cmd_q == fes_pkg::FES_CMD_SUSPEND) ? fes_pkg::D_SUSPEND :
                     (cmd_q == fes_pkg::FES_CMD_RESUME)  ? fes_pkg::D_RESUME :
                     fes_pkg::D_SECTOR;
  wire sec_tgt = (cmd_q == fes_pkg::FES_CMD_SEC_ADD) |
                 (cmd_q == fes_pkg::FES_CMD_SECTOR & step_q == 3'd5);
  // Command cycles keep the upper address bits at zero, except the sector and program target cycles
  wire [16:0] cyc_a = unl_b ? fes_pkg::A_2AA :
                      (sec_tgt | (prog & step_q == 3'd3)) ? addr_q :
                      single ? 17'h00000 : fes_pkg::A_555;
  wire [7:0] cyc_d = single ? one_d : unl_a ? fes_pkg::D_UNL1 : unl_b ? fes_pkg::D_UNL2 :
                     (step_q == 3'd2) ? set_d :
                     prog ? wdata_q :
                     (cmd_q == fes_pkg::FES_CMD_CHIP) ? fes_pkg::D_CHIP : fes_pkg::D_SECTOR;
  wire sec_end = (cmd_q == fes_pkg::FES_CMD_SECTOR) | (cmd_q == fes_pkg::FES_CMD_SEC_ADD);
  wire rd_ok   = (tmr_q == 8'h00) & (sync2_q == sync3_q);

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign flash     = pins_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      addr_q      <= 17'h00000;
      wdata_q     <= 8'h00;
    end else begin
      hreadyout_q <= 1'b1;
      wr_pend_q   <= addr_ph & hwrite;
      wr_addr_q   <= haddr;
      if (addr_ph & ~hwrite) begin
        hrdata_q <= rmux;
      end
      if (wr_addr & ~busy) begin
        addr_q <= hwdata[16:0];
      end
      if (wr_wdata & ~busy) begin
        wdata_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      sync3_q <= 8'h00;
    end else begin
      sync1_q <= dq_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Gap timer mirrors the device's accumulation window
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q  <= 16'h0000;
      win_q  <= 1'b0;
      late_q <= 1'b0;
      susp_q <= 1'b0;
    end else begin
      if (st_q == fes_pkg::FES_ST_WHIGH && tmr_q == 8'h00 && last_wr) begin
        if (sec_end) begin
          // Count from the strobe rise, as the device does, so the host's window closes first
          gap_q <= 16'(fes_pkg::WPH_CYC + 1);
          win_q <= 1'b1;
        end else if (cmd_q != fes_pkg::FES_CMD_SUSPEND) begin
          win_q <= 1'b0;
        end
        if (cmd_q == fes_pkg::FES_CMD_SUSPEND) begin
          susp_q <= 1'b1;
          win_q  <= 1'b0;
        end
        // A reset leaves the device suspended, so only resume clears the mirror
        if (cmd_q == fes_pkg::FES_CMD_RESUME) begin
          susp_q <= 1'b0;
        end
      end else if (win_q) begin
        if (gap_q >= 16'(GAP_CYCLES - 1)) begin
          win_q <= 1'b0;
        end
        gap_q <= gap_q + 16'h0001;
      end
      if (wr_ctrl & hwdata[31] & ~busy) begin
        late_q <= late_add;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= fes_pkg::FES_ST_IDLE;
      cmd_q     <= fes_pkg::FES_CMD_READ;
      step_q    <= 3'd0;
      tmr_q     <= 8'h00;
      rd_q      <= 8'h00;
      prev_rd_q <= 8'h00;
      pins_q    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 17'h00000, dq_out: 8'h00, dq_oe: 1'b0};
    end else begin
      if (tmr_q != 8'h00) begin
        tmr_q <= tmr_q - 8'h01;
      end
      case (st_q)
        fes_pkg::FES_ST_IDLE: begin
          if (go) begin
            cmd_q  <= fes_pkg::fes_cmd_t'(req);
            step_q <= 3'd0;
            st_q   <= (req == fes_pkg::FES_CMD_READ) ? fes_pkg::FES_ST_READ : fes_pkg::FES_ST_WSET;
            tmr_q  <= 8'(fes_pkg::SETUP_CYC);
          end
        end
        fes_pkg::FES_ST_WSET: begin
          // Address settles under chip select before the strobe falls
          pins_q.ce_n   <= 1'b0;
          pins_q.oe_n   <= 1'b1;
          pins_q.addr   <= cyc_a;
          pins_q.dq_out <= cyc_d;
          pins_q.dq_oe  <= 1'b1;
          if (tmr_q == 8'h00) begin
            st_q  <= fes_pkg::FES_ST_WLOW;
            tmr_q <= 8'(fes_pkg::WP_CYC);
          end
        end
        fes_pkg::FES_ST_WLOW: begin
          pins_q.we_n <= 1'b0;
          if (tmr_q == 8'h00) begin
            st_q  <= fes_pkg::FES_ST_WHIGH;
            tmr_q <= 8'(fes_pkg::WPH_CYC);
          end
        end
        fes_pkg::FES_ST_WHIGH: begin
          // Both strobes rise together while data still stands
          pins_q.we_n <= 1'b1;
          pins_q.ce_n <= 1'b1;
          if (tmr_q == 8'h00) begin
            pins_q.dq_oe <= 1'b0;
            step_q       <= step_q + 3'd1;
            tmr_q        <= 8'(fes_pkg::SETUP_CYC);
            // An erase runs on its own inside the device; the host only polls
            st_q <= !last_wr ? fes_pkg::FES_ST_WSET :
                    asel ? fes_pkg::FES_ST_READ : fes_pkg::FES_ST_IDLE;
          end
        end
        fes_pkg::FES_ST_READ: begin
          // Plain reads also serve status polling and suspended-mode reads
          pins_q.ce_n  <= 1'b0;
          pins_q.oe_n  <= 1'b0;
          pins_q.addr  <= addr_q;
          pins_q.dq_oe <= 1'b0;
          if (st_q != fes_pkg::FES_ST_READ || pins_q.oe_n) begin
            tmr_q <= 8'(fes_pkg::ACC_CYC);
          end else if (rd_ok) begin
            prev_rd_q   <= rd_q;
            rd_q        <= sync3_q;
            pins_q.ce_n <= 1'b1;
            pins_q.oe_n <= 1'b1;
            st_q        <= fes_pkg::FES_ST_IDLE;
          end
        end
        default: begin
          st_q <= fes_pkg::FES_ST_IDLE;
        end
      endcase
    end
  end
endmodule : fes_host

// ==== common/fes_pkg.sv ====
package fes_pkg;
  localparam int unsigned CLK_NS       = 4;
  localparam int unsigned T_SETUP_NS   = 20;
  localparam int unsigned T_WP_NS      = 40;
  localparam int unsigned T_WPH_NS     = 30;
  localparam int unsigned T_ACC_NS     = 60;
  localparam int unsigned GAP_US       = 50;
  localparam int unsigned SETUP_CYC    = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WP_CYC       = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WPH_CYC      = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACC_CYC      = (T_ACC_NS + CLK_NS - 1) / CLK_NS + 3;
  localparam int unsigned GAP_CYC      = (GAP_US * 1000) / CLK_NS;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_ADDR     = 8'h04;
  localparam logic [7:0]  OFS_WDATA    = 8'h08;
  localparam logic [7:0]  OFS_STATUS   = 8'h0C;
  localparam logic [16:0] A_555        = 17'h00555;
  localparam logic [16:0] A_2AA        = 17'h002AA;
  localparam logic [7:0]  D_UNL1       = 8'hAA;
  localparam logic [7:0]  D_UNL2       = 8'h55;
  localparam logic [7:0]  D_ERASE_SET  = 8'h80;
  localparam logic [7:0]  D_CHIP       = 8'h10;
  localparam logic [7:0]  D_SECTOR     = 8'h30;
  localparam logic [7:0]  D_PROG_SET   = 8'hA0;
  localparam logic [7:0]  D_AUTOSEL    = 8'h90;
  localparam logic [7:0]  D_RESET      = 8'hF0;
  localparam logic [7:0]  D_SUSPEND    = 8'hB0;
  localparam logic [7:0]  D_RESUME     = 8'h30;
  typedef enum logic [3:0] {
    FES_CMD_READ    = 4'h0,
    FES_CMD_RESET   = 4'h1,
    FES_CMD_PROGRAM = 4'h2,
    FES_CMD_CHIP    = 4'h3,
    FES_CMD_SECTOR  = 4'h4,
    FES_CMD_SEC_ADD = 4'h5,
    FES_CMD_SUSPEND = 4'h6,
    FES_CMD_RESUME  = 4'h7,
    FES_CMD_AUTOSEL = 4'h8
  } fes_cmd_t;
  typedef enum logic [2:0] {
    FES_ST_IDLE  = 3'b000,
    FES_ST_WSET  = 3'b001,
    FES_ST_WLOW  = 3'b010,
    FES_ST_WHIGH = 3'b011,
    FES_ST_READ  = 3'b100
  } fes_state_t;
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [16:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } fes_pins_t;
endpackage : fes_pkg

// ==== bench/fes_host_sva.sv ====
`timescale 1ns/1ps
module fes_host_chk (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire fes_pkg::fes_pins_t flash
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_BUS_OKAY: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus wait or error");
  AST_RESET_IDLE: assert property ($rose(hresetn) |-> flash.ce_n && flash.we_n && !flash.dq_oe && hrdata == 32'h0)
    else $error("pins busy after reset");
  AST_WRITE_GATE: assert property (!flash.we_n |-> !flash.ce_n && flash.oe_n && flash.dq_oe) else $error("bad gate");
  AST_WE_WIDTH: assert property ($fell(flash.we_n) |-> !flash.we_n [*8]) else $error("short strobe");
  AST_ADDR_SETUP: assert property ($fell(flash.we_n) |-> !$past(flash.ce_n, 2) && $stable(flash.addr))
    else $error("addr setup");
  AST_HOLD_LOW: assert property (!flash.we_n && !$past(flash.we_n) |-> $stable(flash.addr) && $stable(flash.dq_out))
    else $error("bus moved");
  AST_DATA_HOLD: assert property ($rose(flash.we_n) |=> $stable(flash.dq_out) && flash.dq_oe) else $error("data hold");
  AST_READ_RELEASE: assert property (!flash.oe_n |-> !flash.dq_oe && flash.we_n) else $error("read contention");
endmodule : fes_host_chk
bind fes_host fes_host_chk fes_host_chk_i (.hclk(hclk), .hresetn(hresetn), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .flash(flash));

// ==== bench/fes_flash_model.sv ====
`timescale 1ns/1ps
module fes_flash_model #(
  parameter int         WIN_NS   = 800,
  parameter int         ERASE_NS = 20000,
  parameter logic [7:0] MAKER_ID = 8'h11,  // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h22,  // Arbitrary value
  parameter logic [7:0] CONT_ID  = 8'h33   // Arbitrary value
) (
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  dq_out,
  output wire logic [7:0]  dq_in
);
  // Mode 0 array, 1 autoselect, 2 chip erase, 3 window, 4 sector erase, 5 suspended
  int          mode = 0, back = 0, step = 0, p, nwr = 0;
  time         t0 = 0;
  logic        wr_ok = 1'b0, tgl = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [16:0] a_q = 17'h0;
  logic [7:0]  d, rd, last_d = 8'h00, held = 8'h00;
  function automatic logic at(input logic [11:0] a);
    return a_q[11:0] == a;
  endfunction : at
  always @* begin
    case (mode)
      1: rd = (addr[1:0] == 2'd0) ? MAKER_ID : (addr[1:0] == 2'd1) ? PART_ID : (addr[1:0] == 2'd3) ? CONT_ID : 8'h00;
      2, 3, 4: rd = {1'b0, tgl, 2'b00, mode != 3, 3'b000};
      5: rd = 8'h80;
      default: rd = addr[7:0] ^ 8'h5A;
    endcase
  end
  // A released bus shows the inverse of the last byte, so stale data never passes
  assign dq_in = (!ce_n && !oe_n) ? rd : held;
  always @(posedge oe_n) begin
    held = ~rd;
    tgl = ~tgl;
  end
  always @(negedge we_n) begin
    a_q = addr;
    wr_ok = !ce_n;
  end
  always @(posedge we_n) if (wr_ok) begin
    d = dq_out;
    last_d = d;
    nwr++;
    p = step;
    if (mode == 4 && d == 8'hB0) mode = 5;
    else if (mode == 3 && d == 8'h30) begin sel[a_q[16:15]] = 1'b1; t0 = $time; end
    else if (mode == 3) mode = (d == 8'hB0) ? 5 : 0;
    else if (mode == 1) mode = (d == 8'hF0) ? back : 1;
    else if (mode == 5 && p == 0 && d == 8'h30) begin mode = 4; t0 = $time; end
    else if (mode == 0 || mode == 5) begin
      step = 0;
      if (p == 0 && at(12'h555) && d == 8'hAA) step = 1;
      if (p == 1 && at(12'h2AA) && d == 8'h55) step = 2;
      if (p == 2 && at(12'h555) && d == 8'h80 && mode == 0) step = 3;
      if (p == 2 && at(12'h555) && d == 8'hA0) step = 6;
      if (p == 2 && at(12'h555) && d == 8'h90) begin back = mode; mode = 1; end
      if (p == 3 && at(12'h555) && d == 8'hAA) step = 4;
      if (p == 4 && at(12'h2AA) && d == 8'h55) step = 5;
      if (p == 5 && at(12'h555) && d == 8'h10) begin mode = 2; t0 = $time; end
      if (p == 5 && d == 8'h30) begin mode = 3; sel = 4'h1 << a_q[16:15]; t0 = $time; end
    end
  end
  always #20 begin
    if (mode == 3 && $time - t0 >= WIN_NS) begin mode = 4; t0 = $time; end
    if ((mode == 2 || mode == 4) && $time - t0 >= ERASE_NS) mode = 0;
  end
endmodule : fes_flash_model

// ==== bench/fes_host_bench.sv ====
`timescale 1ns/1ps
module fes_host_bench;
  typedef struct packed {
    logic [3:0]  c;
    logic [16:0] a;
    logic [7:0]  d;
    logic [2:0]  m;
    logic [7:0]  e;
  } fes_row_t;
  logic               hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [1:0]         htrans = 2'b00;
  logic [7:0]         haddr = 8'h00, dq_in;
  logic [31:0]        hwdata = 32'h0, hrdata, st;
  fes_pkg::fes_pins_t flash;
  int                 n_errors = 0, total_checks = 0, n;
  fes_row_t           rows [11] = '{'{4'h1, 17'h0, 8'h0, 3'h0, 8'hF0}, '{4'h2, 17'h1234, 8'h3C, 3'h0, 8'h3C},
    '{4'h8, 17'h0, 8'h0, 3'h1, 8'h11}, '{4'h0, 17'h1, 8'h0, 3'h1, 8'h22}, '{4'h0, 17'h3, 8'h0, 3'h1, 8'h33},
    '{4'h0, 17'h2, 8'h0, 3'h1, 8'h00}, '{4'h1, 17'h0, 8'h0, 3'h0, 8'hF0}, '{4'h0, 17'h10, 8'h0, 3'h0, 8'h4A},
    '{4'h3, 17'h0, 8'h0, 3'h2, 8'h10}, '{4'h6, 17'h0, 8'h0, 3'h2, 8'hB0}, '{4'h1, 17'h0, 8'h0, 3'h2, 8'hF0}};
  fes_host #(.GAP_CYCLES(200)) fes_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .flash(flash), .dq_in(dq_in));
  fes_flash_model fes_flash_model_i (.ce_n(flash.ce_n), .we_n(flash.we_n), .oe_n(flash.oe_n), .addr(flash.addr),
    .dq_out(flash.dq_out), .dq_in(dq_in));
  initial forever #2 hclk = ~hclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Waits for the sequencer to go idle; refused commands never raise busy
  task automatic run(input logic [3:0] c, input logic [16:0] a, input logic [7:0] d);
    ahb(1'b1, fes_pkg::OFS_ADDR, {15'h0, a}, st);
    ahb(1'b1, fes_pkg::OFS_WDATA, {24'h0, d}, st);
    ahb(1'b1, fes_pkg::OFS_CTRL, {1'b1, 27'h0, c}, st);
    for (int k = 0; k < 300; k++) begin
      ahb(1'b0, fes_pkg::OFS_STATUS, 32'h0, st);
      if (st[0] === 1'b0) break;
    end
    chk({31'h0, st[0]}, 32'h0);
  endtask : run
  initial begin
    repeat (40000) @(posedge hclk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 8'h40, 32'hFFFFFFFF, st);
    ahb(1'b0, 8'h40, 32'h0, st);
    chk(st, 32'h0);
    foreach (rows[i]) begin
      run(rows[i].c, rows[i].a, rows[i].d);
      chk(fes_flash_model_i.mode, {29'h0, rows[i].m});
      chk({24'h0, (rows[i].c inside {4'h0, 4'h8}) ? st[15:8] : fes_flash_model_i.last_d}, {24'h0, rows[i].e});
    end
    repeat (5100) @(posedge hclk);
    chk(fes_flash_model_i.mode, 32'h0);
    run(4'h4, 17'h08000, 8'h00);
    chk({28'h0, fes_flash_model_i.sel}, 32'h2);
    run(4'h0, 17'h08000, 8'h00);
    chk({31'h0, st[3]}, 32'h0);
    run(4'h5, 17'h18000, 8'h00);
    chk({28'h0, fes_flash_model_i.sel, st[1:0]}, 32'h2A);
    run(4'h6, 17'h0, 8'h00);
    chk({fes_flash_model_i.mode[3:0], st[31]}, 32'hB);
    run(4'h7, 17'h0, 8'h00);
    n = fes_flash_model_i.nwr;
    run(4'h7, 17'h0, 8'h00);
    chk({fes_flash_model_i.mode[15:0], 16'(fes_flash_model_i.nwr - n)}, 32'h40000);
    run(4'h6, 17'h0, 8'h00);
    chk(fes_flash_model_i.mode, 32'h5);
    run(4'h7, 17'h0, 8'h00);
    repeat (5100) @(posedge hclk);
    chk(fes_flash_model_i.mode, 32'h0);
    run(4'h4, 17'h0, 8'h00);
    repeat (300) @(posedge hclk);
    n = fes_flash_model_i.nwr;
    run(4'h5, 17'h08000, 8'h00);
    chk({st[2], fes_flash_model_i.nwr[3:0]}, {1'b1, 4'(n)});
    run(4'h0, 17'h0, 8'h00);
    chk({31'h0, st[3]}, 32'h1);
    repeat (5100) @(posedge hclk);
    run(4'h4, 17'h10000, 8'h00);
    n = fes_flash_model_i.nwr;
    run(4'h2, 17'h00100, 8'h77);
    chk({fes_flash_model_i.mode[15:0], 16'(fes_flash_model_i.nwr - n)}, 32'h4);
    // Reset in mid-run cuts a reset command before its strobe falls
    ahb(1'b1, fes_pkg::OFS_CTRL, {1'b1, 27'h0, 4'h1}, st);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({27'h0, flash.ce_n, flash.we_n, flash.oe_n, flash.dq_oe, hreadyout}, 32'h1D);
    hresetn <= 1'b1;
    ahb(1'b0, fes_pkg::OFS_STATUS, 32'h0, st);
    chk(st, 32'h0);
    run(4'h1, 17'h0, 8'h00);
    chk({24'h0, fes_flash_model_i.last_d}, 32'hF0);
    report_and_stop();
  end
endmodule : fes_host_bench
